// file: design/flash_map.svh
// offsets, field positions, reset values and timing figures of the flash command controller
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

`define FLASH_STATUS_ADDR     32'hffff_0e00
`define FLASH_MODE_ADDR       32'hffff_0e04
`define FLASH_COMMAND_ADDR    32'hffff_0e08
`define FLASH_DATA_ADDR       32'hffff_0e0c
`define FLASH_ADDRESS_ADDR    32'hffff_0e10
`define FLASH_SIGNATURE_ADDR  32'hffff_0e18
`define FLASH_PROTECT_ADDR    32'hffff_0e1c

`define STATUS_PASS_BIT       0
`define STATUS_FAIL_BIT       1
`define STATUS_BUSY_BIT       2
`define STATUS_IRQ_BIT        3
`define STATUS_FIXED_BIT      5
`define MODE_WREN_BIT         3
`define MODE_IRQEN_BIT        4
`define MODE_KEY_LSB          5
`define MODE_KEY_MSB          6
`define MODE_KEY_PATTERN      2'h2

`define STATUS_RESET          16'h0020
`define MODE_RESET            16'h0000
`define COMMAND_RESET         8'h07
`define COMMAND_READBACK      8'h07
`define ADDRESS_RESET         16'h0000
`define DATA_RESET            16'h0000
`define SIGNATURE_RESET       24'hff_ffff
`define PROTECT_RESET         32'h0000_0000
`define KEY_RESET             32'hffff_ffff
`define ERASED_WORD           16'hffff
`define MASS_ERASE_KEY        16'hffc3

`define PAGE_BYTES            512
`define PAGE_WORDS            256
`define USER_WORDS            15360
`define USER_TOP_ADDR         16'h77ff

`define CLOCK_PERIOD_NS       5
`define WRITE_TIME_NS         50000
`define ERASE_WRITE_TIME_NS   24000000
`define SIGN_CYCLES           16389

`endif

// file: design/flash_pkg.sv
// types shared by the flash command controller
package flash_pkg;

  typedef enum logic [7:0] {
    CMD_NULL        = 8'h00,
    CMD_READ        = 8'h01,
    CMD_WRITE       = 8'h02,
    CMD_ERASE_WRITE = 8'h03,
    CMD_VERIFY      = 8'h04,
    CMD_PAGE_ERASE  = 8'h05,
    CMD_MASS_ERASE  = 8'h06,
    CMD_SIGNATURE   = 8'h0b,
    CMD_PROTECT     = 8'h0c,
    CMD_PING        = 8'h0f
  } flash_cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ERASE = 5'b00010,
    ST_WAIT  = 5'b00100,
    ST_SIGN  = 5'b01000,
    ST_DONE  = 5'b10000
  } flash_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// file: design/flash_command_controller.sv
// flash command sequencer with its status, mode, command, data, address and signature registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "flash_map.svh"

module flash_command_controller
  import flash_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES       = `WRITE_TIME_NS / `CLOCK_PERIOD_NS,
  parameter int unsigned ERASE_WRITE_CYCLES = `ERASE_WRITE_TIME_NS / `CLOCK_PERIOD_NS,
  parameter int unsigned SIGN_CYCLES        = `SIGN_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire reg_req_t    reg_req,
  output logic [31:0]      rd_data,
  // events
  output logic             flash_irq,
  output logic             data_abort
);

  logic [15:0]  mem [0:`USER_WORDS-1];

  flash_state_t state_reg, state_next;
  logic [7:0]   op_reg;
  logic [15:0]  mode_reg;
  logic [7:0]   command_reg;
  logic [15:0]  data_reg;
  logic [15:0]  address_reg;
  logic [23:0]  signature_reg;
  logic [23:0]  signature_shift_register_reg;
  logic [31:0]  protect_reg;
  logic [31:0]  protect_saved_reg;
  logic [31:0]  key_reg;
  logic         protect_done_reg;
  logic         pass_reg;
  logic         fail_reg;
  logic         irq_reg;
  logic         done_ok_reg;
  logic         abort_reg;
  logic [22:0]  cnt_reg;
  logic [13:0]  idx_reg;
  logic [13:0]  last_reg;
  logic [31:0]  rd_data_reg;

  // protection bit covering a page: two pages per bit below 58, one each above
  function automatic logic [4:0] page_bit(input logic [6:0] page);
    if (page >= 7'd59)
      return 5'd30;
    else if (page == 7'd58)
      return 5'd29;
    else
      return page[5:1];
  endfunction

  // bus decode
  wire        sel_status  = reg_req.addr == `FLASH_STATUS_ADDR;
  wire        sel_mode    = reg_req.addr == `FLASH_MODE_ADDR;
  wire        sel_command = reg_req.addr == `FLASH_COMMAND_ADDR;
  wire        sel_data    = reg_req.addr == `FLASH_DATA_ADDR;
  wire        sel_address = reg_req.addr == `FLASH_ADDRESS_ADDR;
  wire        sel_sig     = reg_req.addr == `FLASH_SIGNATURE_ADDR;
  wire        sel_protect = reg_req.addr == `FLASH_PROTECT_ADDR;
  wire        status_read = reg_req.rd && sel_status;

  // command decode
  wire        idle        = state_reg == ST_IDLE;
  wire        start       = reg_req.wr && sel_command && idle;
  wire [7:0]  code        = reg_req.wdata[7:0];
  wire        addr_ok     = address_reg <= `USER_TOP_ADDR;
  wire [13:0] word_idx    = address_reg[14:1];
  wire [13:0] page_first  = {address_reg[14:9], 8'h00};
  wire [13:0] page_last   = {address_reg[14:9], 8'hff};
  wire        page_open   = !protect_done_reg || protect_saved_reg[page_bit(address_reg[15:9])];
  wire        wren        = mode_reg[`MODE_WREN_BIT];
  wire        write_ok    = wren && addr_ok && page_open;
  wire        key_mode    = mode_reg[`MODE_KEY_MSB:`MODE_KEY_LSB] == `MODE_KEY_PATTERN;
  wire        key_match   = key_reg == {address_reg, data_reg};
  wire        protect_ok  = wren && key_mode && (!protect_done_reg || key_match);
  wire        mass_ok     = wren && data_reg == `MASS_ERASE_KEY;
  wire [15:0] mem_word    = mem[word_idx];
  wire        cmd_readback = code <= CMD_MASS_ERASE;

  // signature shift register, one array word folded in per cycle
  wire        signature_shift_register_fb     = signature_shift_register_reg[23] ^ signature_shift_register_reg[22] ^ signature_shift_register_reg[21] ^ signature_shift_register_reg[16];
  wire [23:0] signature_shift_register_next   = {signature_shift_register_reg[22:0], signature_shift_register_fb} ^ {8'h00, mem[idx_reg]};
  wire [13:0] idx_wrap    = (idx_reg == 14'(`USER_WORDS - 1)) ? 14'h0000 : idx_reg + 14'h0001;

  // array write port
  wire        write_start = start && code == CMD_WRITE && write_ok;
  wire        write_late  = state_reg == ST_WAIT && op_reg == CMD_ERASE_WRITE
                            && cnt_reg == 23'h00_0001;
  wire        erase_step  = state_reg == ST_ERASE;
  wire        mem_we      = write_start || write_late || erase_step;
  wire [13:0] mem_idx     = erase_step ? idx_reg : word_idx;
  wire [15:0] mem_wdata   = erase_step ? `ERASED_WORD : data_reg;

  // start decision: target state and immediate outcome
  logic start_ok;
  logic start_abort;
  always_comb begin
    state_next  = state_reg;
    start_ok    = 1'b0;
    start_abort = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          unique case (code)
            CMD_READ: begin
              start_ok    = addr_ok;
              start_abort = !addr_ok;
              state_next  = ST_DONE;
            end
            CMD_WRITE: begin
              start_abort = !addr_ok;
              state_next  = write_ok ? ST_WAIT : ST_DONE;
            end
            CMD_ERASE_WRITE, CMD_PAGE_ERASE: begin
              start_abort = code == CMD_ERASE_WRITE && !addr_ok;
              state_next  = write_ok ? ST_ERASE : ST_DONE;
            end
            CMD_VERIFY: begin
              start_ok    = addr_ok && mem_word == data_reg;
              state_next  = ST_DONE;
            end
            CMD_MASS_ERASE: state_next = mass_ok ? ST_ERASE : ST_DONE;
            CMD_SIGNATURE:  state_next = ST_SIGN;
            CMD_PROTECT: begin
              start_ok    = protect_ok;
              state_next  = ST_DONE;
            end
            CMD_PING: begin
              start_ok    = 1'b1;
              state_next  = ST_DONE;
            end
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_ERASE: begin
        if (idx_reg == last_reg)
          state_next = (op_reg == CMD_ERASE_WRITE) ? ST_WAIT : ST_DONE;
      end
      ST_WAIT: begin
        if (cnt_reg == 23'h00_0001)
          state_next = ST_DONE;
      end
      ST_SIGN: begin
        if (cnt_reg == 23'h00_0001)
          state_next = ST_DONE;
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (mem_we)
      mem[mem_idx] <= mem_wdata;
  end

  // sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      op_reg      <= `COMMAND_RESET;
      done_ok_reg <= 1'b0;
      abort_reg   <= 1'b0;
      cnt_reg     <= 23'h00_0000;
      idx_reg     <= 14'h0000;
      last_reg    <= 14'h0000;
      signature_shift_register_reg    <= `SIGNATURE_RESET;
    end else begin
      state_reg <= state_next;
      abort_reg <= start_abort;
      if (start) begin
        op_reg      <= code;
        done_ok_reg <= start_ok;
        idx_reg     <= (code == CMD_MASS_ERASE || code == CMD_SIGNATURE) ? 14'h0000 : page_first;
        last_reg    <= (code == CMD_MASS_ERASE) ? 14'(`USER_WORDS - 1) : page_last;
        signature_shift_register_reg    <= `SIGNATURE_RESET;
        cnt_reg     <= (code == CMD_SIGNATURE) ? 23'(SIGN_CYCLES) : 23'(WRITE_CYCLES);
      end else if (state_reg == ST_ERASE) begin
        idx_reg     <= idx_reg + 14'h0001;
        done_ok_reg <= 1'b1;
        if (idx_reg == last_reg)
          cnt_reg <= 23'(ERASE_WRITE_CYCLES - (last_reg - page_first + 1));
      end else if (state_reg == ST_WAIT) begin
        cnt_reg     <= cnt_reg - 23'h00_0001;
        done_ok_reg <= 1'b1;
      end else if (state_reg == ST_SIGN) begin
        cnt_reg     <= cnt_reg - 23'h00_0001;
        idx_reg     <= idx_wrap;
        signature_shift_register_reg    <= signature_shift_register_next;
        done_ok_reg <= 1'b1;
      end
    end
  end

  // software registers and command side effects
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_reg          <= `MODE_RESET;
      command_reg       <= `COMMAND_RESET;
      data_reg          <= `DATA_RESET;
      address_reg       <= `ADDRESS_RESET;
      signature_reg     <= `SIGNATURE_RESET;
      protect_reg       <= `PROTECT_RESET;
      protect_saved_reg <= `PROTECT_RESET;
      key_reg           <= `KEY_RESET;
      protect_done_reg  <= 1'b0;
    end else begin
      if (reg_req.wr && sel_mode)
        mode_reg <= reg_req.wdata[15:0];
      if (reg_req.wr && sel_command && idle)
        command_reg <= cmd_readback ? `COMMAND_READBACK : code;
      if (start && code == CMD_READ && addr_ok)
        data_reg <= mem_word;
      else if (reg_req.wr && sel_data)
        data_reg <= reg_req.wdata[15:0];
      if (reg_req.wr && sel_address)
        address_reg <= reg_req.wdata[15:0];
      if (reg_req.wr && sel_protect)
        protect_reg <= reg_req.wdata;
      if (state_reg == ST_SIGN && cnt_reg == 23'h00_0001)
        signature_reg <= signature_shift_register_next;
      if (start && code == CMD_PROTECT && protect_ok) begin
        protect_saved_reg <= protect_reg;
        key_reg           <= {address_reg, data_reg};
        protect_done_reg  <= 1'b1;
      end else if (state_reg == ST_ERASE && op_reg == CMD_MASS_ERASE && idx_reg == last_reg) begin
        protect_saved_reg <= `PROTECT_RESET;
        key_reg           <= `KEY_RESET;
        protect_done_reg  <= 1'b0;
      end
    end
  end

  // status flags: a completion in the same cycle as a status read wins over the clear
  wire finishing = state_reg == ST_DONE;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pass_reg <= 1'b0;
      fail_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      pass_reg <= (finishing && done_ok_reg) || (pass_reg && !status_read);
      fail_reg <= (finishing && !done_ok_reg) || (fail_reg && !status_read);
      irq_reg  <= (finishing && mode_reg[`MODE_IRQEN_BIT])
                  || (irq_reg && !status_read);
    end
  end

  // read mux; unmapped addresses read zero
  logic [15:0] status_value;
  always_comb begin
    status_value                    = `STATUS_RESET;
    status_value[`STATUS_PASS_BIT]  = pass_reg;
    status_value[`STATUS_FAIL_BIT]  = fail_reg;
    status_value[`STATUS_BUSY_BIT]  = !idle;
    status_value[`STATUS_IRQ_BIT]   = irq_reg;
  end

  wire [31:0] rd_mux =
      sel_status  ? {16'h0000, status_value} :
      sel_mode    ? {16'h0000, mode_reg} :
      sel_command ? {24'h00_0000, command_reg} :
      sel_data    ? {16'h0000, data_reg} :
      sel_address ? {16'h0000, address_reg} :
      sel_sig     ? {8'h00, signature_reg} :
      sel_protect ? protect_reg : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rst_n)
      rd_data_reg <= 32'h0000_0000;
    else
      rd_data_reg <= reg_req.rd ? rd_mux : 32'h0000_0000;
  end

  assign rd_data    = rd_data_reg;
  assign flash_irq  = irq_reg;
  assign data_abort = abort_reg;

  // checks
  sequence cmd_issue(logic [7:0] c);
    start && code == c;
  endsequence

  sequence finish_seq;
    state_reg == ST_DONE;
  endsequence

  cmd_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    start && cmd_readback |=> command_reg == `COMMAND_READBACK)
    else $error("command register not 0x07 after command");

  pass_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish_seq and done_ok_reg |=> pass_reg && !$rose(fail_reg)
      ##1 (pass_reg || $past(status_read)))
    else $error("pass flag not set on success");

  fail_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish_seq and !done_ok_reg |=> fail_reg && !$rose(pass_reg))
    else $error("fail flag not set on failure");

  irq_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish_seq and !mode_reg[`MODE_IRQEN_BIT] and !irq_reg |=> !flash_irq)
    else $error("interrupt raised while disabled");

  irq_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish_seq and mode_reg[`MODE_IRQEN_BIT] |=> flash_irq && status_value[`STATUS_IRQ_BIT])
    else $error("interrupt not raised on completion");

  write_guard_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_issue(CMD_WRITE) and !wren |=> state_reg == ST_DONE && !done_ok_reg)
    else $error("write ran without enable");

  write_busy_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_issue(CMD_WRITE) and write_ok |=> status_value[`STATUS_BUSY_BIT] [*8])
    else $error("write not busy");

  read_fetch_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_issue(CMD_READ) and addr_ok |=> data_reg == $past(mem_word) ##1 pass_reg)
    else $error("read did not load data word");

  abort_range_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_issue(CMD_READ) and !addr_ok |=> data_abort ##1 fail_reg)
    else $error("out of range read not aborted");

  page_erase_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_issue(CMD_PAGE_ERASE) and write_ok |=> idx_reg[7:0] == 8'h00
      ##0 (state_reg == ST_ERASE) [*8])
    else $error("page erase does not start at page base");

  sign_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_SIGN && cnt_reg == 23'h00_0001 |=> signature_reg == $past(signature_shift_register_next)
      && state_reg == ST_DONE)
    else $error("signature not loaded at end");

  reserved_a: assert property (@(posedge clock) disable iff (!rst_n)
    start && (code inside {8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e}) |=> idle
      && $stable(data_reg))
    else $error("reserved command had an effect");

  // a ping holds busy for its one done cycle only, then reports a pass
  ping_done_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_issue(CMD_PING) |=> status_value[`STATUS_BUSY_BIT]
      ##1 (!status_value[`STATUS_BUSY_BIT] && pass_reg))
    else $error("ping did not complete");

endmodule

// file: tb/flash_command_controller_tb_top.sv
// self-checking testbench of the flash command controller
`timescale 1ns/1ps
`include "flash_map.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end

module flash_command_controller_tb_top import flash_pkg::*;;
  // short counts keep the long commands inside the run budget
  localparam int unsigned WC = 8;
  localparam int unsigned EWC = 300;
  localparam int unsigned SC = 20;

  logic        clock;
  logic        rst_n;
  reg_req_t    reg_req;
  logic [31:0] rd_data;
  logic        flash_irq;
  logic        data_abort;
  int          failures;
  int          checked;
  int          aborts = 0;
  int          polls;
  logic [31:0] v;
  logic [3:0]  acc;
  logic [23:0] sig;
  logic [31:0] reg_addr [7];
  logic [31:0] reg_rst [7];
  logic [7:0]  reserved [6];

  flash_command_controller #(
    .WRITE_CYCLES       (WC),
    .ERASE_WRITE_CYCLES (EWC),
    .SIGN_CYCLES        (SC)
  ) flash_command_controller_inst (
    .clock      (clock),
    .rst_n      (rst_n),
    .reg_req    (reg_req),
    .rd_data    (rd_data),
    .flash_irq  (flash_irq),
    .data_abort (data_abort)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (data_abort === 1'b1) aborts++;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  // polling clears the sticky flags, so they are gathered over every poll
  task automatic go(input logic [7:0] code);
    wr(`FLASH_COMMAND_ADDR, {24'h0, code});
    acc = 4'h0;
    polls = 0;
    do begin
      rd(`FLASH_STATUS_ADDR, v);
      acc |= v[3:0] & 4'hb;
      polls++;
    end while (v[2] === 1'b1 && polls < 20000);
    `CHK("busy ends", 1'b1, polls < 20000)
  endtask

  task automatic cmd(input logic [7:0] code, input logic [3:0] exp, input int n);
    go(code);
    `CHK("flags", exp, acc)
    if (n != 0) `CHK("busy polls", n, polls)
  endtask

  task automatic ld(input logic [15:0] a, input logic [15:0] d);
    wr(`FLASH_ADDRESS_ADDR, {16'h0, a});
    wr(`FLASH_DATA_ADDR, {16'h0, d});
  endtask

  task automatic rdw(input logic [15:0] a, input logic [15:0] exp);
    ld(a, 16'h0000);
    cmd(CMD_READ, 4'h1, 0);
    rd(`FLASH_DATA_ADDR, v);
    `CHK("word", exp, v[15:0])
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #400_000;
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim;
  end

  initial begin
    reg_req = '0;
    rst_n = 1'b0;
    failures = 0;
    checked = 0;
    reg_addr = '{`FLASH_STATUS_ADDR, `FLASH_MODE_ADDR, `FLASH_COMMAND_ADDR, `FLASH_DATA_ADDR,
                 `FLASH_ADDRESS_ADDR, `FLASH_SIGNATURE_ADDR, 32'hffff_0e14};
    reg_rst = '{32'h0000_0020, 32'h0000_0000, 32'h0000_0007, 32'h0000_0000,
                32'h0000_0000, 32'h00ff_ffff, 32'h0000_0000};
    reserved = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (reg_addr[i]) begin
      rd(reg_addr[i], v);
      `CHK("reset value", reg_rst[i], v)
    end
    // completion interrupt held until status is read
    wr(`FLASH_MODE_ADDR, 32'h0000_0110);
    wr(`FLASH_COMMAND_ADDR, {24'h0, CMD_PING});
    repeat (3) @(posedge clock);
    #1 `CHK("irq raised", 1'b1, flash_irq)
    rd(`FLASH_STATUS_ADDR, v);
    `CHK("ping status", 4'h9, v[3:0])
    repeat (2) @(posedge clock);
    #1 `CHK("irq cleared", 1'b0, flash_irq)
    rd(`FLASH_STATUS_ADDR, v);
    `CHK("flags cleared", 4'h0, v[3:0])
    rd(`FLASH_COMMAND_ADDR, v);
    `CHK("ping code", 32'h0000_000f, v)
    wr(`FLASH_MODE_ADDR, 32'h0000_0100);
    cmd(CMD_PING, 4'h1, 0);
    `CHK("no irq", 1'b0, flash_irq)
    cmd(CMD_NULL, 4'h0, 0);
    rd(`FLASH_COMMAND_ADDR, v);
    `CHK("null code", 32'h0000_0007, v)
    ld(16'h0100, 16'h5a5a);
    foreach (reserved[i]) begin
      cmd(reserved[i], 4'h0, 0);
      rd(`FLASH_COMMAND_ADDR, v);
      `CHK("reserved code", {24'h0, reserved[i]}, v)
      rd(`FLASH_DATA_ADDR, v);
      `CHK("data kept", 32'h0000_5a5a, v)
    end
    // write refused while the enable is clear
    ld(16'h0100, 16'h1234);
    cmd(CMD_WRITE, 4'h2, 0);
    rd(`FLASH_COMMAND_ADDR, v);
    `CHK("write code", 32'h0000_0007, v)
    wr(`FLASH_MODE_ADDR, 32'h0000_0108);
    cmd(CMD_WRITE, 4'h1, (WC + 1) / 2 + 1);
    ld(16'h0000, 16'hbeef);
    cmd(CMD_WRITE, 4'h1, 0);
    ld(16'h0200, 16'h4321);
    cmd(CMD_WRITE, 4'h1, 0);
    rdw(16'h0100, 16'h1234);
    ld(16'h0100, 16'h1234);
    cmd(CMD_VERIFY, 4'h1, 0);
    ld(16'h0100, 16'h1235);
    cmd(CMD_VERIFY, 4'h2, 0);
    cmd(CMD_PAGE_ERASE, 4'h1, (256 + 1) / 2 + 1);
    rdw(16'h0000, 16'hffff);
    rdw(16'h0100, 16'hffff);
    rdw(16'h0200, 16'h4321);
    ld(16'h0202, 16'h7777);
    cmd(CMD_ERASE_WRITE, 4'h1, (EWC + 1) / 2 + 1);
    rdw(16'h0202, 16'h7777);
    rdw(16'h0200, 16'hffff);
    `CHK("no abort", 0, aborts)
    ld(16'h7800, 16'h0000);
    go(CMD_READ);
    `CHK("read abort", 1, aborts)
    cmd(CMD_WRITE, 4'h2, 0);
    `CHK("write abort", 2, aborts)
    cmd(CMD_SIGNATURE, 4'h1, (SC + 1) / 2 + 1);
    // words 0 to SC-1 all hold the erased value here
    sig = 24'hff_ffff;
    for (int i = 0; i < SC; i++) begin
      sig = {sig[22:0], sig[23] ^ sig[22] ^ sig[21] ^ sig[16]} ^ 24'h00_ffff;
    end
    rd(`FLASH_SIGNATURE_ADDR, v);
    `CHK("signature loaded", {8'h00, sig}, v)
    // pages 32 and 33 locked under key 66bb_aa55
    wr(`FLASH_PROTECT_ADDR, 32'hfffe_ffff);
    ld(16'h66bb, 16'haa55);
    wr(`FLASH_MODE_ADDR, 32'h0000_0148);
    cmd(CMD_PROTECT, 4'h1, 0);
    wr(`FLASH_MODE_ADDR, 32'h0000_0108);
    ld(16'h4000, 16'h1111);
    cmd(CMD_WRITE, 4'h2, 0);
    ld(16'h0400, 16'h1111);
    cmd(CMD_WRITE, 4'h1, 0);
    ld(16'h66bb, 16'haa54);
    wr(`FLASH_MODE_ADDR, 32'h0000_0148);
    cmd(CMD_PROTECT, 4'h2, 0);
    wr(`FLASH_MODE_ADDR, 32'h0000_0108);
    ld(16'h0000, 16'h1234);
    cmd(CMD_MASS_ERASE, 4'h2, 0);
    ld(16'h0000, 16'hffc3);
    cmd(CMD_MASS_ERASE, 4'h1, (`USER_WORDS + 1) / 2 + 1);
    rdw(16'h0400, 16'hffff);
    ld(16'h4000, 16'h2222);
    cmd(CMD_WRITE, 4'h1, 0);
    rdw(16'h4000, 16'h2222);
    end_sim;
  end
endmodule
